// ### wdc_pkg.sv
// package: register map, field layout and timing constants of the watchdog control block
package wdc_pkg;

  // register byte addresses
  localparam logic [31:0] WDC_CTRL_ADDR = 32'h0000_003c;
  localparam logic [31:0] WDC_SERVICE_ADDR = 32'h0000_0040;
  localparam logic [31:0] WDC_CONFIG_ADDR = 32'h0000_0044;
  localparam logic [31:0] WDC_STATUS_ADDR = 32'h0000_0048;
  localparam logic [31:0] WDC_MASK_ADDR = 32'h0000_004c;
  localparam logic [31:0] WDC_COUNT_ADDR = 32'h0000_0050;

  // watchdog_control_register fields
  localparam int WDC_WINDOW_POS = 7;
  localparam int WDC_STOPDBG_POS = 6;
  localparam int WDC_WRMASK_POS = 5;
  localparam int WDC_RATE_LSB = 0;
  localparam int WDC_RATE_W = 3;

  // configuration register fields
  localparam int WDC_CLKSEL_POS = 0;
  localparam int WDC_PSTOP_POS = 1;
  localparam int WDC_PCE_POS = 2;

  // status and mask fields
  localparam int WDC_ST_TIMEOUT = 0;
  localparam int WDC_ST_WINDOW = 1;
  localparam int WDC_ST_BADSEQ = 2;
  localparam int WDC_ST_SERVICED = 3;
  localparam int WDC_ST_W = 4;

  // reset values before the flash load
  localparam logic WDC_WINDOW_RST = 1'b0;
  localparam logic WDC_STOPDBG_RST = 1'b0;
  localparam logic [2:0] WDC_RATE_RST = 3'h0;
  localparam logic [2:0] WDC_CONFIG_RST = 3'h0;
  localparam logic [3:0] WDC_MASK_RST = 4'h0;

  // rates and service sequence
  localparam logic [2:0] WDC_RATE_OFF = 3'h0;
  localparam logic [4:0] WDC_EXP_LONGEST = 5'h18;
  localparam logic [34:0] WDC_EXP_TABLE = {5'h18, 5'h17, 5'h16, 5'h14, 5'h12, 5'h10, 5'h0e};
  localparam logic [7:0] WDC_SVC_ARM = 8'h55;
  localparam logic [7:0] WDC_SVC_FIRE = 8'haa;
  localparam int WDC_CNT_W = 25;

  typedef enum logic [0:0] {WDC_SVC_IDLE, WDC_SVC_ARMED} wdc_svc_t;

  typedef struct packed {
    logic window;
    logic stop_in_debug;
    logic [2:0] rate;
  } wdc_ctrl_t;

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [1:0] sync3;
    logic loaded;
    logic written_once;
    wdc_ctrl_t ctrl;
    logic [2:0] config_bits;
    logic [WDC_ST_W-1:0] status;
    logic [WDC_ST_W-1:0] mask;
    wdc_svc_t svc;
    logic [WDC_CNT_W-1:0] count;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sys_reset;
    logic freeze;
    logic irq;
  } wdc_state_t;

endpackage

// ### wdc_top.sv
// watchdog control: control register, rates, window servicing and timeout reset
//
// Behaviour
// - special mode any write; normal only sets
// - normal mode window/rate written once, unmasked
// - special mode window/rate unmasked writes always
// - rate zero or window zero keeps value
// - write mask discards, no write-once use
// - load from flash; nonzero rate starts
// - clock-select change or oscillator loss restarts
// - normal restart on rate, window, debug-stop set
// - special mode any control write restarts
// - window mode: early service causes reset
// - first value repeats; second value restarts
// - stop-in-debug halts counters in debug
// - nonzero rate enables; timeout raises reset
// - special debug run: longest, non-windowed
// - rate codes map to listed exponents
// - counter clock from rc or oscillator
// - stop halts unless pseudo-stop with oscillator and PCE set
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
module wdc_top
  import wdc_pkg::*;
#(
  parameter int unsigned EXP_SHRINK = 0
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // device modes, same clock
  input wire logic SPECIAL_MODE,
  input wire logic DEBUG_ACTIVE,
  input wire logic STOP_MODE,
  // flash defaults, valid when reset releases
  input wire logic FLASH_WINDOW,
  input wire logic [2:0] FLASH_RATE,
  // asynchronous pins
  input wire logic OSC_GOOD,
  input wire logic RC_CLK_IN,
  input wire logic OSC_CLK_IN,
  // results
  output logic WATCHDOG_RESET,
  output logic TIMER_FREEZE,
  output logic IRQ
);

  function automatic logic addr_mapped(input logic [31:0] a);
    addr_mapped = (a == WDC_CTRL_ADDR) || (a == WDC_SERVICE_ADDR) || (a == WDC_CONFIG_ADDR) ||
                  (a == WDC_STATUS_ADDR) || (a == WDC_MASK_ADDR) || (a == WDC_COUNT_ADDR);
  endfunction

  function automatic logic [4:0] rate_exp(input logic [2:0] r);
    // rate zero never counts; keep the index in range anyway
    if (r == WDC_RATE_OFF) begin
      rate_exp = WDC_EXP_LONGEST;
    end else begin
      rate_exp = WDC_EXP_TABLE[5*(r-3'h1) +: 5];
    end
  endfunction

  wdc_state_t s;
  wdc_state_t s_n;

  logic setup;
  logic wr;
  logic [7:0] d;
  logic restart;
  logic rc_tick;
  logic osc_tick;
  logic osc_good;
  logic tick;
  logic enabled;
  logic override;
  logic halt;
  logic [4:0] exp_eff;
  logic [WDC_CNT_W-1:0] period;
  logic [WDC_CNT_W-1:0] open_at;
  logic [WDC_ST_W-1:0] st_set;
  logic [WDC_ST_W-1:0] st_clr;
  logic early;

  always_comb begin
    s_n = s;
    restart = 1'b0;
    st_set = '0;
    st_clr = '0;
    // pins pass two flops; the third only feeds edge detection
    s_n.sync1 = {OSC_GOOD, OSC_CLK_IN, RC_CLK_IN};
    s_n.sync2 = s.sync1;
    s_n.sync3 = s.sync2[1:0];
    rc_tick = s.sync2[0] & ~s.sync3[0];
    osc_tick = s.sync2[1] & ~s.sync3[1];
    osc_good = s.sync2[2];
    tick = s.config_bits[WDC_CLKSEL_POS] ? osc_tick : rc_tick;

    enabled = (s.ctrl.rate != WDC_RATE_OFF);
    override = enabled && DEBUG_ACTIVE && !s.ctrl.stop_in_debug && SPECIAL_MODE;
    exp_eff = override ? WDC_EXP_LONGEST : rate_exp(s.ctrl.rate);
    exp_eff = exp_eff - 5'(EXP_SHRINK);
    period = WDC_CNT_W'(1) << exp_eff;
    open_at = period - (period >> 2);
    early = s.ctrl.window && !override && (s.count < open_at);
    // counters freeze in debug with stop-in-debug set, or in stop unless pseudo-stop on oscillator with PCE set
    halt = (DEBUG_ACTIVE && s.ctrl.stop_in_debug) ||
           (STOP_MODE && !(s.config_bits[WDC_PSTOP_POS] && s.config_bits[WDC_CLKSEL_POS] &&
                           s.config_bits[WDC_PCE_POS]));

    // apb: zero wait, answer prepared in the setup cycle
    setup = PSEL && !PENABLE;
    wr = PSEL && PENABLE && PWRITE && s.pready;
    d = PWDATA[7:0];
    s_n.pready = setup;
    s_n.pslverr = setup && !addr_mapped(PADDR);
    s_n.prdata = '0;
    if (setup && !PWRITE) begin
      case (PADDR)
        WDC_CTRL_ADDR: begin
          s_n.prdata[WDC_WINDOW_POS] = s.ctrl.window;
          s_n.prdata[WDC_STOPDBG_POS] = s.ctrl.stop_in_debug;
          s_n.prdata[WDC_RATE_LSB +: WDC_RATE_W] = s.ctrl.rate;
        end
        WDC_CONFIG_ADDR: s_n.prdata[2:0] = s.config_bits;
        WDC_STATUS_ADDR: s_n.prdata[WDC_ST_W-1:0] = s.status;
        WDC_MASK_ADDR: s_n.prdata[WDC_ST_W-1:0] = s.mask;
        WDC_COUNT_ADDR: s_n.prdata[WDC_CNT_W-1:0] = s.count;
        default: s_n.prdata = '0;
      endcase
    end

    // one-time load of flash defaults after reset release
    if (!s.loaded) begin
      s_n.loaded = 1'b1;
      s_n.ctrl.window = FLASH_WINDOW;
      s_n.ctrl.rate = FLASH_RATE;
      restart = 1'b1;
    end

    if (wr && PADDR == WDC_CTRL_ADDR) begin
      if (SPECIAL_MODE) begin
        s_n.ctrl.stop_in_debug = d[WDC_STOPDBG_POS];
        restart = 1'b1;
      end else if (d[WDC_STOPDBG_POS]) begin
        s_n.ctrl.stop_in_debug = 1'b1;
        if (!s.ctrl.stop_in_debug) begin
          restart = 1'b1;
        end
      end
      // write mask drops the field write and keeps the allowance
      if (!d[WDC_WRMASK_POS] && (SPECIAL_MODE || !s.written_once)) begin
        s_n.written_once = !SPECIAL_MODE || s.written_once;
        if (d[WDC_RATE_LSB +: WDC_RATE_W] != WDC_RATE_OFF) begin
          s_n.ctrl.rate = d[WDC_RATE_LSB +: WDC_RATE_W];
          restart = 1'b1;
        end
        if (d[WDC_WINDOW_POS]) begin
          s_n.ctrl.window = 1'b1;
          restart = 1'b1;
        end
      end
    end

    if (wr && PADDR == WDC_CONFIG_ADDR) begin
      s_n.config_bits = d[2:0];
      if (d[WDC_CLKSEL_POS] != s.config_bits[WDC_CLKSEL_POS]) begin
        restart = 1'b1;
      end
    end
    // losing the oscillator falls back to the rc clock
    if (!osc_good && s_n.config_bits[WDC_CLKSEL_POS]) begin
      s_n.config_bits[WDC_CLKSEL_POS] = 1'b0;
      restart = 1'b1;
    end

    if (wr && PADDR == WDC_MASK_ADDR) begin
      s_n.mask = d[WDC_ST_W-1:0];
    end
    if (wr && PADDR == WDC_STATUS_ADDR) begin
      st_clr = d[WDC_ST_W-1:0];
    end

    // service sequence
    if (wr && PADDR == WDC_SERVICE_ADDR && enabled) begin
      if (early) begin
        st_set[WDC_ST_WINDOW] = 1'b1;
      end else begin
        case (s.svc)
          WDC_SVC_IDLE: begin
            if (d == WDC_SVC_ARM) begin
              s_n.svc = WDC_SVC_ARMED;
            end else begin
              st_set[WDC_ST_BADSEQ] = 1'b1;
            end
          end
          WDC_SVC_ARMED: begin
            if (d == WDC_SVC_FIRE) begin
              restart = 1'b1;
              st_set[WDC_ST_SERVICED] = 1'b1;
            end else if (d != WDC_SVC_ARM) begin
              st_set[WDC_ST_BADSEQ] = 1'b1;
            end
          end
          default: s_n.svc = WDC_SVC_IDLE;
        endcase
      end
    end

    // counter
    if (restart) begin
      s_n.count = '0;
      s_n.svc = WDC_SVC_IDLE;
    end else if (enabled && tick && !halt) begin
      if (s.count == period - WDC_CNT_W'(1)) begin
        st_set[WDC_ST_TIMEOUT] = 1'b1;
        s_n.count = '0;
      end else begin
        s_n.count = s.count + WDC_CNT_W'(1);
      end
    end

    // any reset cause holds the system reset until the device is reset
    if (st_set[WDC_ST_TIMEOUT] || st_set[WDC_ST_WINDOW] || st_set[WDC_ST_BADSEQ]) begin
      s_n.sys_reset = 1'b1;
    end
    // a new event wins over a same-cycle clear
    s_n.status = (s.status & ~st_clr) | st_set;
    s_n.irq = |(s_n.status & s_n.mask);
    s_n.freeze = DEBUG_ACTIVE && s_n.ctrl.stop_in_debug;
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s <= '{sync1: 3'h0, sync2: 3'h0, sync3: 2'h0, loaded: 1'b0, written_once: 1'b0,
             ctrl: '{window: WDC_WINDOW_RST, stop_in_debug: WDC_STOPDBG_RST, rate: WDC_RATE_RST},
             config_bits: WDC_CONFIG_RST, status: 4'h0, mask: WDC_MASK_RST, svc: WDC_SVC_IDLE,
             count: 25'h000_0000, prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0,
             sys_reset: 1'b0, freeze: 1'b0, irq: 1'b0};
    end else begin
      s <= s_n;
    end
  end

  assign PRDATA = s.prdata;
  assign PREADY = s.pready;
  assign PSLVERR = s.pslverr;
  assign WATCHDOG_RESET = s.sys_reset;
  assign TIMER_FREEZE = s.freeze;
  assign IRQ = s.irq;

endmodule

// ### wdc_monitor.sv
// port checker of the watchdog control block, bound to its top
`timescale 1ns/10ps
module wdc_monitor
  import wdc_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // modes and results
  input wire logic DEBUG_ACTIVE,
  input wire logic WATCHDOG_RESET,
  input wire logic TIMER_FREEZE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  logic mapped;
  assign mapped = PADDR inside {WDC_CTRL_ADDR, WDC_SERVICE_ADDR, WDC_CONFIG_ADDR,
    WDC_STATUS_ADDR, WDC_MASK_ADDR, WDC_COUNT_ADDR};
  a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  a_ready_in_access: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access");
  a_err_unmapped: assert property (PREADY |-> PSLVERR == !mapped)
    else $error("error flag wrong for address");
  a_err_reads_zero: assert property (PSLVERR |-> PRDATA == 32'h0000_0000)
    else $error("refused access returned data");
  a_write_data_zero: assert property (PREADY && PWRITE |-> PRDATA == 32'h0000_0000)
    else $error("read data during write");
  a_ctrl_read_shape: assert property (
    PREADY && !PWRITE && PADDR == WDC_CTRL_ADDR |-> PRDATA[31:8] == 0 && PRDATA[5:3] == 0)
    else $error("control read shows unused bits");
  a_reset_sticky: assert property (WATCHDOG_RESET |=> WATCHDOG_RESET)
    else $error("watchdog reset dropped");
  a_freeze_needs_debug: assert property (TIMER_FREEZE |-> $past(DEBUG_ACTIVE))
    else $error("freeze without debug");
endmodule

bind wdc_top wdc_monitor mon (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .DEBUG_ACTIVE(DEBUG_ACTIVE), .WATCHDOG_RESET(WATCHDOG_RESET), .TIMER_FREEZE(TIMER_FREEZE));

// ### wdc_top_test.sv
// self-checking bench of the watchdog control block
`timescale 1ns/10ps
module wdc_top_test;
  import wdc_pkg::*;
  logic CLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [31:0] PADDR = '0, PWDATA = '0, PRDATA, rd;
  logic PREADY, PSLVERR, WATCHDOG_RESET, TIMER_FREEZE, IRQ, err;
  logic SPECIAL_MODE = 0, DEBUG_ACTIVE = 0, STOP_MODE = 0, FLASH_WINDOW = 0, OSC_GOOD = 1;
  logic [2:0] FLASH_RATE = '0;
  logic RC_CLK_IN = 0, OSC_CLK_IN = 0;
  int failures = 0, n_compared = 0, cycles = 0;
  // shrink of 10: rate 1 needs 16 watchdog edges, one edge every 4 cycles
  wdc_top #(.EXP_SHRINK(10)) uut (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .SPECIAL_MODE(SPECIAL_MODE),
    .DEBUG_ACTIVE(DEBUG_ACTIVE), .STOP_MODE(STOP_MODE), .FLASH_WINDOW(FLASH_WINDOW),
    .FLASH_RATE(FLASH_RATE), .OSC_GOOD(OSC_GOOD), .RC_CLK_IN(RC_CLK_IN),
    .OSC_CLK_IN(OSC_CLK_IN), .WATCHDOG_RESET(WATCHDOG_RESET), .TIMER_FREEZE(TIMER_FREEZE),
    .IRQ(IRQ));
  always #25 CLK = ~CLK;
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    // each level lasts two cycles so the synchroniser never misses one
    if (cycles[0]) RC_CLK_IN <= ~RC_CLK_IN;
    OSC_CLK_IN <= RC_CLK_IN;
    if (cycles == 40000) begin
      failures++;
      close_out;
    end
  end
  task automatic check(input logic [31:0] seen, exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, d);
    @(posedge CLK);
    PSEL <= 1;
    PENABLE <= 0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task automatic restart(input logic sp, w, input logic [2:0] r);
    @(posedge CLK);
    RESET_N <= 0;
    SPECIAL_MODE <= sp;
    FLASH_WINDOW <= w;
    FLASH_RATE <= r;
    DEBUG_ACTIVE <= 0;
    repeat (20) @(posedge CLK);
    RESET_N <= 1;
    repeat (2) @(posedge CLK);
  endtask
  task automatic test_write_once;
    restart(0, 0, 3'h0);
    apb(1, WDC_CTRL_ADDR, 32'h0000_00a3);
    apb(0, WDC_CTRL_ADDR, 0);
    check(rd, 0, "masked write");
    apb(1, WDC_CTRL_ADDR, 32'h0000_0000);
    apb(1, WDC_CTRL_ADDR, 32'h0000_0082);
    apb(1, WDC_CTRL_ADDR, 32'h0000_0040);
    apb(1, WDC_CTRL_ADDR, 32'h0000_0000);
    apb(0, WDC_CTRL_ADDR, 0);
    check(rd, 32'h0000_0040, "write once");
    DEBUG_ACTIVE <= 1;
    repeat (3) @(posedge CLK);
    check(32'(TIMER_FREEZE), 1, "freeze");
    apb(0, 32'h0000_0080, 0);
    check(32'(err), 1, "unmapped");
    $display("test write_once done");
  endtask
  task automatic test_rates;
    int cyc;
    for (int r = 1; r <= 4; r++) begin
      cyc = 64 << (2 * (r - 1));
      restart(1, 0, 3'h0);
      apb(1, WDC_CTRL_ADDR, 32'h0000_0001);
      apb(1, WDC_CTRL_ADDR, 32'(r));
      repeat (cyc * 3 / 4) @(posedge CLK);
      apb(0, WDC_CTRL_ADDR, 0);
      check(rd, 32'(r), "rate stored");
      check(32'(WATCHDOG_RESET), 0, "early timeout");
      repeat (cyc / 2 + 20) @(posedge CLK);
      check(32'(WATCHDOG_RESET), 1, "timeout");
    end
    $display("test rates done");
  endtask
  task automatic test_service;
    restart(0, 0, 3'h1);
    repeat (6) begin
      repeat (20) @(posedge CLK);
      apb(1, WDC_SERVICE_ADDR, 32'h0000_0055);
      apb(1, WDC_SERVICE_ADDR, 32'h0000_0055);
      apb(1, WDC_SERVICE_ADDR, 32'h0000_00aa);
    end
    check(32'(WATCHDOG_RESET), 0, "serviced");
    restart(0, 1, 3'h2);
    repeat (215) @(posedge CLK);
    apb(1, WDC_SERVICE_ADDR, 32'h0000_0055);
    apb(1, WDC_SERVICE_ADDR, 32'h0000_00aa);
    repeat (20) @(posedge CLK);
    check(32'(WATCHDOG_RESET), 0, "late service");
    restart(0, 1, 3'h2);
    apb(1, WDC_SERVICE_ADDR, 32'h0000_0055);
    repeat (3) @(posedge CLK);
    check(32'(WATCHDOG_RESET), 1, "early service");
    check(32'(IRQ), 0, "masked irq");
    apb(1, WDC_MASK_ADDR, 32'h0000_0002);
    repeat (2) @(posedge CLK);
    check(32'(IRQ), 1, "irq raised");
    apb(1, WDC_STATUS_ADDR, 32'h0000_0002);
    repeat (2) @(posedge CLK);
    check(32'(IRQ), 0, "irq cleared");
    $display("test service done");
  endtask
  task automatic test_clocks;
    logic [31:0] c0;
    restart(0, 0, 3'h1);
    apb(1, WDC_CTRL_ADDR, 32'h0000_0060);
    repeat (12) @(posedge CLK);
    DEBUG_ACTIVE <= 1;
    repeat (4) @(posedge CLK);
    apb(0, WDC_COUNT_ADDR, 0);
    c0 = rd;
    repeat (20) @(posedge CLK);
    apb(0, WDC_COUNT_ADDR, 0);
    check(rd, c0, "halt in debug");
    DEBUG_ACTIVE <= 0;
    repeat (20) @(posedge CLK);
    apb(0, WDC_COUNT_ADDR, 0);
    check(32'(rd > c0), 1, "runs after debug");
    STOP_MODE <= 1;
    repeat (4) @(posedge CLK);
    apb(0, WDC_COUNT_ADDR, 0);
    c0 = rd;
    repeat (20) @(posedge CLK);
    apb(0, WDC_COUNT_ADDR, 0);
    check(rd, c0, "halt in stop");
    STOP_MODE <= 0;
    check(32'(c0 > 2), 1, "count grown");
    apb(1, WDC_CONFIG_ADDR, 32'h0000_0001);
    apb(0, WDC_COUNT_ADDR, 0);
    check(32'(rd < 2), 1, "clock select restart");
    OSC_GOOD <= 0;
    repeat (4) @(posedge CLK);
    apb(0, WDC_CONFIG_ADDR, 0);
    check(rd, 0, "oscillator loss");
    OSC_GOOD <= 1;
    restart(1, 1, 3'h1);
    DEBUG_ACTIVE <= 1;
    repeat (2) @(posedge CLK);
    apb(1, WDC_SERVICE_ADDR, 32'h0000_0055);
    repeat (3) @(posedge CLK);
    check(32'(WATCHDOG_RESET), 0, "override no window");
    repeat (100) @(posedge CLK);
    check(32'(WATCHDOG_RESET), 0, "override longest");
    DEBUG_ACTIVE <= 0;
    $display("test clocks done");
  endtask
  task automatic close_out;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    test_write_once;
    test_rates;
    test_service;
    test_clocks;
    close_out;
  end
endmodule
